// ==== hdl/tcd_decoder.sv ====
/*
 Command decoder and control register bank of a sub-GHz transceiver.
 Serial side runs on the link clock; registers run on core_clk_in.
 Assumes the host meets SPI mode 0 with chip select low for whole
 words and at least one core_clk_in period plus sync lag between
 chip select falling and the first serial clock edge.
*/
`timescale 1ns/1ps

module tcd_decoder (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic spi_sck_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_sdi_in,
	output logic spi_sdo_out,
	output logic spi_sdo_oe_out,
	input wire logic tx_ready_rx_fill_flag_in,
	input wire logic power_on_flag_in,
	input wire logic underrun_overflow_flag_in,
	input wire logic wake_timer_flag_in,
	input wire logic external_edge_flag_in,
	input wire logic low_supply_flag_in,
	input wire logic fifo_empty_flag_in,
	input wire logic signal_strength_flag_in,
	input wire logic data_quality_flag_in,
	input wire logic clock_lock_flag_in,
	input wire logic freq_cycle_toggle_in,
	input wire logic offset_sign_in,
	input wire logic [tcd_pkg::OFFS_W-1:0] offset_value_in,
	input wire logic [tcd_pkg::BYTE_W-1:0] rx_byte_value_in,
	output logic event_pending_out,
	output logic tx_byte_load_out,
	output logic rx_byte_taken_out,
	output logic [tcd_pkg::PL8-1:0] general_config_out,
	output logic [tcd_pkg::PL8-1:0] freq_control_config_out,
	output logic [tcd_pkg::PL9-1:0] transmit_config_out,
	output logic [tcd_pkg::PL8-1:0] tx_byte_value_out,
	output logic [tcd_pkg::PL12-1:0] frequency_value_out,
	output logic [tcd_pkg::PL11-1:0] receive_control_out,
	output logic [tcd_pkg::PL8-1:0] baseband_filter_out,
	output logic [tcd_pkg::PL8-1:0] fifo_reset_config_out,
	output logic [tcd_pkg::PL8-1:0] sync_pattern_value_out,
	output logic [tcd_pkg::PL8-1:0] data_rate_out,
	output logic [tcd_pkg::PL8-1:0] power_management_out,
	output logic [tcd_pkg::PL13-1:0] wake_timer_period_out,
	output logic [tcd_pkg::PL8-1:0] duty_cycle_out,
	output logic [tcd_pkg::PL8-1:0] supply_threshold_clock_out,
	output logic [tcd_pkg::PL8-1:0] pll_config_out
);

	// ****************************************
	// Link clock domain: shift in
	// ****************************************
	// Chip select high holds the serial side in reset, so a partial
	// word can never survive into the next frame.
	logic spi_arst_n;
	logic [tcd_pkg::CNT_W-1:0] bit_cnt_r;
	logic [tcd_pkg::WORD_W-1:0] shift_r;
	logic [tcd_pkg::WORD_W-1:0] shift_nxt;
	logic first_bit_r;
	logic fifo_rd_r;
	logic [tcd_pkg::BYTE_W-1:0] code_byte;
	logic [tcd_pkg::WORD_W-1:0] word_hold_r;
	logic word_tgl_r;
	logic word_done;

	assign spi_arst_n = nrst_in & ~spi_cs_n_in;
	assign shift_nxt = {shift_r[tcd_pkg::WORD_W-2:0], spi_sdi_in};
	assign code_byte = shift_nxt[tcd_pkg::BYTE_W-1:0];
	assign word_done = (bit_cnt_r == tcd_pkg::LAST_BIT);

	always_ff @(posedge spi_sck_in or negedge spi_arst_n) begin
		if (!spi_arst_n) begin
			bit_cnt_r <= '0;
			shift_r <= '0;
			first_bit_r <= 1'b0;
			fifo_rd_r <= 1'b0;
		end else begin
			bit_cnt_r <= bit_cnt_r + 4'h1;
			shift_r <= shift_nxt;
			if (bit_cnt_r == '0) begin
				first_bit_r <= spi_sdi_in;
			end
			if (bit_cnt_r == tcd_pkg::CODE_BYTE_BIT) begin
				fifo_rd_r <= (code_byte == tcd_pkg::CODE_RXF);
			end
		end
	end

	// Holding word survives chip select rising; next word needs 16 more
	// edges, so the core side always reads it while stable.
	always_ff @(posedge spi_sck_in or negedge nrst_in) begin
		if (!nrst_in) begin
			word_hold_r <= '0;
			word_tgl_r <= 1'b0;
		end else if (word_done) begin
			word_hold_r <= shift_nxt;
			word_tgl_r <= ~word_tgl_r;
		end
	end

	// ****************************************
	// Link clock domain: shift out
	// ****************************************
	logic sdo_r;
	logic sdo_nxt;
	logic first_fall_r;
	logic [tcd_pkg::CNT_W-1:0] out_idx;
	logic [tcd_pkg::WORD_W-1:0] status_snap_r;
	logic [tcd_pkg::BYTE_W-1:0] rx_snap_r;
	logic rx_phase;

	// Bits sent so far equals bits received, so the next is 15 - count
	assign out_idx = ~bit_cnt_r;
	assign rx_phase = fifo_rd_r && (bit_cnt_r >= tcd_pkg::LOW_BYTE_BIT);
	assign sdo_nxt = !first_bit_r ? status_snap_r[out_idx] :
		(rx_phase ? rx_snap_r[out_idx[2:0]] : 1'b0);

	always_ff @(negedge spi_sck_in or negedge spi_arst_n) begin
		if (!spi_arst_n) begin
			sdo_r <= 1'b0;
			first_fall_r <= 1'b1;
		end else begin
			sdo_r <= sdo_nxt;
			first_fall_r <= 1'b0;
		end
	end

	// Bit 15 must stand before the first clock edge of the frame
	assign spi_sdo_out = spi_cs_n_in ? 1'b0 :
		(first_fall_r ? status_snap_r[tcd_pkg::WORD_W-1] : sdo_r);
	assign spi_sdo_oe_out = ~spi_cs_n_in;

	// ****************************************
	// Crossing into the core clock
	// ****************************************
	logic cs_s1_r;
	logic cs_idle_r;
	logic tgl_s1_r;
	logic tgl_s2_r;
	logic tgl_s3_r;
	logic word_evt;
	logic [tcd_pkg::WORD_W-1:0] word;

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cs_s1_r <= 1'b1;
			cs_idle_r <= 1'b1;
			tgl_s1_r <= 1'b0;
			tgl_s2_r <= 1'b0;
			tgl_s3_r <= 1'b0;
		end else begin
			cs_s1_r <= spi_cs_n_in;
			cs_idle_r <= cs_s1_r;
			tgl_s1_r <= word_tgl_r;
			tgl_s2_r <= tgl_s1_r;
			tgl_s3_r <= tgl_s2_r;
		end
	end

	assign word_evt = tgl_s2_r ^ tgl_s3_r;
	assign word = word_hold_r;

	// ****************************************
	// Command decode
	// ****************************************
	logic [tcd_pkg::NREG-1:0] hit;
	logic [tcd_pkg::NREG-1:0] wr_sel;
	logic hit_status;
	logic hit_rxf;
	logic [7:0] up8;

	assign up8 = word[tcd_pkg::WORD_W-1:tcd_pkg::LSB8];
	assign hit_status = !word[tcd_pkg::WORD_W-1];
	assign hit_rxf = (up8 == tcd_pkg::CODE_RXF);
	assign hit[tcd_pkg::IX_GEN] = (up8 == tcd_pkg::CODE_GEN);
	assign hit[tcd_pkg::IX_AFC] = (up8 == tcd_pkg::CODE_AFC);
	assign hit[tcd_pkg::IX_TXC] =
		(word[tcd_pkg::WORD_W-1:tcd_pkg::LSB7] == tcd_pkg::CODE_TXC);
	assign hit[tcd_pkg::IX_TXB] = (up8 == tcd_pkg::CODE_TXB);
	assign hit[tcd_pkg::IX_CFS] =
		(word[tcd_pkg::WORD_W-1:tcd_pkg::LSB4] == tcd_pkg::CODE_CFS);
	assign hit[tcd_pkg::IX_RXC] =
		(word[tcd_pkg::WORD_W-1:tcd_pkg::LSB5] == tcd_pkg::CODE_RXC);
	assign hit[tcd_pkg::IX_BBF] = (up8 == tcd_pkg::CODE_BBF);
	assign hit[tcd_pkg::IX_FIFO] = (up8 == tcd_pkg::CODE_FIFO);
	assign hit[tcd_pkg::IX_SYNC] = (up8 == tcd_pkg::CODE_SYNC);
	assign hit[tcd_pkg::IX_DRATE] = (up8 == tcd_pkg::CODE_DRATE);
	assign hit[tcd_pkg::IX_PMC] = (up8 == tcd_pkg::CODE_PMC);
	assign hit[tcd_pkg::IX_WAKE] =
		(word[tcd_pkg::WORD_W-1:tcd_pkg::LSB3] == tcd_pkg::CODE_WAKE);
	assign hit[tcd_pkg::IX_DUTY] = (up8 == tcd_pkg::CODE_DUTY);
	assign hit[tcd_pkg::IX_BCS] = (up8 == tcd_pkg::CODE_BCS);
	assign hit[tcd_pkg::IX_PLL] = (up8 == tcd_pkg::CODE_PLL);
	// Codes are disjoint, so a word reaches at most one register
	assign wr_sel = word_evt ? hit : '0;

	// ****************************************
	// Register bank
	// ****************************************
	logic [tcd_pkg::WORD_W-1:0] reg_r [tcd_pkg::NREG];

	generate
		for (genvar i = 0; i < tcd_pkg::NREG; i++) begin : g_reg
			always_ff @(posedge core_clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					reg_r[i] <= tcd_pkg::RST_VAL[i];
				end else if (wr_sel[i]) begin
					reg_r[i] <= word;
				end
			end
		end
	endgenerate

	assign general_config_out = reg_r[tcd_pkg::IX_GEN][tcd_pkg::PL8-1:0];
	assign freq_control_config_out =
		reg_r[tcd_pkg::IX_AFC][tcd_pkg::PL8-1:0];
	assign transmit_config_out = reg_r[tcd_pkg::IX_TXC][tcd_pkg::PL9-1:0];
	assign tx_byte_value_out = reg_r[tcd_pkg::IX_TXB][tcd_pkg::PL8-1:0];
	assign frequency_value_out = reg_r[tcd_pkg::IX_CFS][tcd_pkg::PL12-1:0];
	assign receive_control_out = reg_r[tcd_pkg::IX_RXC][tcd_pkg::PL11-1:0];
	assign baseband_filter_out = reg_r[tcd_pkg::IX_BBF][tcd_pkg::PL8-1:0];
	assign fifo_reset_config_out =
		reg_r[tcd_pkg::IX_FIFO][tcd_pkg::PL8-1:0];
	assign sync_pattern_value_out =
		reg_r[tcd_pkg::IX_SYNC][tcd_pkg::PL8-1:0];
	assign data_rate_out = reg_r[tcd_pkg::IX_DRATE][tcd_pkg::PL8-1:0];
	assign power_management_out = reg_r[tcd_pkg::IX_PMC][tcd_pkg::PL8-1:0];
	assign wake_timer_period_out =
		reg_r[tcd_pkg::IX_WAKE][tcd_pkg::PL13-1:0];
	assign duty_cycle_out = reg_r[tcd_pkg::IX_DUTY][tcd_pkg::PL8-1:0];
	assign supply_threshold_clock_out =
		reg_r[tcd_pkg::IX_BCS][tcd_pkg::PL8-1:0];
	assign pll_config_out = reg_r[tcd_pkg::IX_PLL][tcd_pkg::PL8-1:0];

	// ****************************************
	// Status word and strobes
	// ****************************************
	logic [tcd_pkg::N_STICKY-1:0] sticky_r;
	logic [tcd_pkg::N_STICKY-1:0] sticky_set;
	logic sticky_clr;
	logic [tcd_pkg::WORD_W-1:0] status_live;
	logic tx_load_r;
	logic rx_taken_r;

	assign sticky_set = {tx_ready_rx_fill_flag_in, power_on_flag_in,
		underrun_overflow_flag_in, wake_timer_flag_in,
		external_edge_flag_in};
	assign sticky_clr = word_evt && hit_status;

	generate
		for (genvar j = 0; j < tcd_pkg::N_STICKY; j++) begin : g_flag
			always_ff @(posedge core_clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					sticky_r[j] <= 1'b0;
				end else if (sticky_set[j]) begin
					// Set wins so an event in the read cycle is kept
					sticky_r[j] <= 1'b1;
				end else if (sticky_clr) begin
					sticky_r[j] <= 1'b0;
				end
			end
		end
	endgenerate

	assign status_live = {sticky_r, low_supply_flag_in, fifo_empty_flag_in,
		signal_strength_flag_in, data_quality_flag_in, clock_lock_flag_in,
		freq_cycle_toggle_in, offset_sign_in, offset_value_in};
	assign event_pending_out = |sticky_r;

	// Snapshots freeze while selected so the serial side reads steady
	// bits; the price is status up to a frame old.
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			status_snap_r <= tcd_pkg::STATUS_RST;
			rx_snap_r <= '0;
			tx_load_r <= 1'b0;
			rx_taken_r <= 1'b0;
		end else begin
			if (cs_idle_r) begin
				status_snap_r <= status_live;
				rx_snap_r <= rx_byte_value_in;
			end
			tx_load_r <= wr_sel[tcd_pkg::IX_TXB];
			rx_taken_r <= word_evt && hit_rxf;
		end
	end

	assign tx_byte_load_out = tx_load_r;
	assign rx_byte_taken_out = rx_taken_r;

endmodule

// ==== hdl/tcd_pkg.sv ====
/*
 Constants for the transceiver command decoder: command codes, reset
 words, field widths, status word layout and serial framing figures.
 Assumes a 16-bit command word sent most significant bit first.
*/
//
// Overview of operation
// - Seventeen commands; fifteen each write one dedicated register, the status and receive reads write none.
// - Each word has a leading command code, then that register's fields.
// - Words shift most significant bit first; bit 15 arrives first.
// - Power-on reset loads every register default before any command.
// - Status word resets to zero; flag layout from bit 15 downward.
// - General configuration code 0x80, reset 0x8008.
// - Frequency-control configuration code 0xc4, reset 0xc4f7.
// - Transmit configuration seven-bit code in bits 15:9, reset 0x9800.
// - Code 0xb8 loads the next transmit byte; reset word 0xb8aa.
// - Code 0xb0 reads the receive byte in the low eight bits.
// - Centre frequency code 1010, twelve-bit value, reset 0xa680.
// - Receive control code 10010, reset 0x9080.
// - Baseband filter code 0xc2, reset 0xc22c.
// - FIFO and reset configuration code 0xca, reset 0xca80.
// - Sync pattern code 0xce, eight-bit pattern, reset 0xced4.
// - Data rate code 0xc6, prescale bit and seven-bit rate, reset 0xc623.
// - Power management code 0x82, eight enables, reset 0x8208.
// - Wake timer code 111, exponent and mantissa, reset 0xe196.
// - Duty cycle code 0xc8, value and enable, reset 0xc80e.
// - Supply threshold and clock output code 0xc0, reset 0xc000.
// - PLL configuration code 0xcc, reset 0xcc77.
// - A word whose first bit is 0 is a status read.
// - Reading the status word clears its latched event flags.
// - Sample on rising, shift out on falling clock edge; clock idles low.

package tcd_pkg;

	// ****************************************
	// Word framing
	// ****************************************
	localparam int WORD_W = 16;
	localparam int CNT_W = 4;
	localparam int BYTE_W = 8;
	localparam logic [CNT_W-1:0] LAST_BIT = 4'hf;
	localparam logic [CNT_W-1:0] CODE_BYTE_BIT = 4'h7;
	localparam logic [CNT_W-1:0] LOW_BYTE_BIT = 4'h8;

	// ****************************************
	// Command code positions and values
	// ****************************************
	localparam int LSB8 = 8;
	localparam int LSB7 = 9;
	localparam int LSB5 = 11;
	localparam int LSB4 = 12;
	localparam int LSB3 = 13;
	localparam logic [7:0] CODE_GEN = 8'h80;
	localparam logic [7:0] CODE_AFC = 8'hc4;
	localparam logic [6:0] CODE_TXC = 7'h4c;
	localparam logic [7:0] CODE_TXB = 8'hb8;
	localparam logic [3:0] CODE_CFS = 4'ha;
	localparam logic [4:0] CODE_RXC = 5'h12;
	localparam logic [7:0] CODE_BBF = 8'hc2;
	localparam logic [7:0] CODE_RXF = 8'hb0;
	localparam logic [7:0] CODE_FIFO = 8'hca;
	localparam logic [7:0] CODE_SYNC = 8'hce;
	localparam logic [7:0] CODE_DRATE = 8'hc6;
	localparam logic [7:0] CODE_PMC = 8'h82;
	localparam logic [2:0] CODE_WAKE = 3'h7;
	localparam logic [7:0] CODE_DUTY = 8'hc8;
	localparam logic [7:0] CODE_BCS = 8'hc0;
	localparam logic [7:0] CODE_PLL = 8'hcc;

	// ****************************************
	// Writable register bank
	// ****************************************
	localparam int NREG = 15;
	localparam int IX_GEN = 0;
	localparam int IX_AFC = 1;
	localparam int IX_TXC = 2;
	localparam int IX_TXB = 3;
	localparam int IX_CFS = 4;
	localparam int IX_RXC = 5;
	localparam int IX_BBF = 6;
	localparam int IX_FIFO = 7;
	localparam int IX_SYNC = 8;
	localparam int IX_DRATE = 9;
	localparam int IX_PMC = 10;
	localparam int IX_WAKE = 11;
	localparam int IX_DUTY = 12;
	localparam int IX_BCS = 13;
	localparam int IX_PLL = 14;
	localparam logic [WORD_W-1:0] RST_VAL [NREG] = '{
		16'h8008, 16'hc4f7, 16'h9800, 16'hb8aa, 16'ha680,
		16'h9080, 16'hc22c, 16'hca80, 16'hced4, 16'hc623,
		16'h8208, 16'he196, 16'hc80e, 16'hc000, 16'hcc77};
	localparam int PL8 = 8;
	localparam int PL9 = 9;
	localparam int PL11 = 11;
	localparam int PL12 = 12;
	localparam int PL13 = 13;

	// ****************************************
	// Status word
	// ****************************************
	localparam logic [WORD_W-1:0] STATUS_RST = 16'h0000;
	localparam int N_STICKY = 5;
	localparam int OFFS_W = 4;

endpackage

// ==== test/tcd_decoder_bench.sv ====
/*
 Self-checking bench for the command decoder.
 Assumes the monitor and host model are compiled before this file.
*/
`timescale 1ns/1ps
module tcd_decoder_bench;
	// ****************************************
	// Stimulus and checks
	// ****************************************
	logic clk = 1'b0;
	logic nrst = 1'b1;
	logic [4:0] ev = 5'h00;
	logic [10:0] lvl = 11'h000;
	logic [7:0] rxb = 8'h00;
	wire logic sck, cs_n, sdi, sdo, pend, ld, tk;
	wire logic [15:0] seen [15];
	logic [15:0] exp_r [15];
	logic [15:0] rd, w, st;
	logic [31:0] seed = 32'haa782eb5;
	logic [31:0] r;
	int fails = 0, n_tests = 0, n_ld = 0, n_tk = 0, cyc = 0, k;
	localparam logic [15:0] BASE [15] = '{16'h8000, 16'hc400, 16'h9800,
		16'hb800, 16'ha000, 16'h9000, 16'hc200, 16'hca00, 16'hce00,
		16'hc600, 16'h8200, 16'he000, 16'hc800, 16'hc000, 16'hcc00};
	localparam int PW [15] = '{8, 8, 9, 8, 12, 11, 8, 8, 8, 8, 8, 13, 8, 8, 8};
	always #2.5 clk = ~clk;
	tcd_host host (.sck_out(sck), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo));
	tcd_decoder dut (.core_clk_in(clk), .nrst_in(nrst), .spi_sck_in(sck),
		.spi_cs_n_in(cs_n), .spi_sdi_in(sdi), .spi_sdo_out(sdo),
		.spi_sdo_oe_out(), .tx_ready_rx_fill_flag_in(ev[4]),
		.power_on_flag_in(ev[3]), .underrun_overflow_flag_in(ev[2]),
		.wake_timer_flag_in(ev[1]), .external_edge_flag_in(ev[0]),
		.low_supply_flag_in(lvl[10]), .fifo_empty_flag_in(lvl[9]),
		.signal_strength_flag_in(lvl[8]), .data_quality_flag_in(lvl[7]),
		.clock_lock_flag_in(lvl[6]), .freq_cycle_toggle_in(lvl[5]),
		.offset_sign_in(lvl[4]), .offset_value_in(lvl[3:0]),
		.rx_byte_value_in(rxb), .event_pending_out(pend),
		.tx_byte_load_out(ld), .rx_byte_taken_out(tk),
		.general_config_out(seen[0][7:0]),
		.freq_control_config_out(seen[1][7:0]),
		.transmit_config_out(seen[2][8:0]), .tx_byte_value_out(seen[3][7:0]),
		.frequency_value_out(seen[4][11:0]),
		.receive_control_out(seen[5][10:0]),
		.baseband_filter_out(seen[6][7:0]),
		.fifo_reset_config_out(seen[7][7:0]),
		.sync_pattern_value_out(seen[8][7:0]), .data_rate_out(seen[9][7:0]),
		.power_management_out(seen[10][7:0]),
		.wake_timer_period_out(seen[11][12:0]),
		.duty_cycle_out(seen[12][7:0]),
		.supply_threshold_clock_out(seen[13][7:0]),
		.pll_config_out(seen[14][7:0]));
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [15:0] msk(int i);
		return (16'h0001 << PW[i]) - 16'h0001;
	endfunction
	task automatic chk(string nm, logic [15:0] got, logic [15:0] expv);
		n_tests++;
		if (got !== expv) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, expv, got);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic send(logic [15:0] wd, int nb);
		host.xfer(wd, nb, rd);
		tick(10);
	endtask
	task automatic check_all();
		for (int i = 0; i < 15; i++) begin
			chk("payload", seen[i] & msk(i), exp_r[i] & msk(i));
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		if (ld === 1'b1) n_ld <= n_ld + 1;
		if (tk === 1'b1) n_tk <= n_tk + 1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			print_verdict();
		end
	end
	initial begin
		// Falling edge once every process waits, so the async resets fire
		nrst <= 1'b0;
		for (int i = 0; i < 15; i++) exp_r[i] = tcd_pkg::RST_VAL[i];
		tick(3);
		nrst <= 1'b1;
		tick(4);
		check_all();
		send(16'h0000, 16);
		chk("status", rd, 16'h0000);
		// First pass all ones hits every code boundary
		for (int p = 0; p < 3; p++) begin
			for (int i = 0; i < 15; i++) begin
				r = (p == 0) ? 32'hffffffff : rnd();
				w = BASE[i] | (r[15:0] & msk(i));
				exp_r[i] = w;
				k = n_ld;
				send(w, 16);
				check_all();
				chk("loads", 16'(n_ld), 16'(k + int'(i == tcd_pkg::IX_TXB)));
			end
		end
		send(16'h80ff, 10);
		check_all();
		send(16'h81ff, 16);
		check_all();
		r = rnd();
		rxb <= r[7:0];
		k = n_tk;
		send(16'hb000, 16);
		chk("rx read", rd, {8'h00, r[7:0]});
		chk("rx taken", 16'(n_tk), 16'(k + 1));
		r = rnd();
		lvl <= r[10:0];
		ev <= r[15:11] | 5'h01;
		tick(1);
		ev <= 5'h00;
		tick(6);
		st = {r[15:11] | 5'h01, r[10:0]};
		chk("pending", 16'(pend), 16'h0001);
		send(16'h0000, 16);
		chk("status", rd, st);
		chk("pending", 16'(pend), 16'h0000);
		send(16'h7fff, 16);
		chk("status", rd, {5'h00, r[10:0]});
		check_all();
		// Second reset after writes must restore every default
		nrst <= 1'b0;
		tick(3);
		nrst <= 1'b1;
		for (int i = 0; i < 15; i++) exp_r[i] = tcd_pkg::RST_VAL[i];
		tick(2);
		check_all();
		chk("pending", 16'(pend), 16'h0000);
		print_verdict();
	end
endmodule
bind tcd_decoder tcd_monitor mon (.*);

// ==== test/tcd_host.sv ====
/*
 Host model for the serial port: mode 0 frames, msb first, sdo capture.
 Assumes one caller at a time; sck stands low between frames.
*/
`timescale 1ns/1ps
module tcd_host (
	output logic sck_out,
	output logic cs_n_out,
	output logic sdi_out,
	input wire logic sdo_in
);
	initial begin
		sck_out = 1'b0;
		cs_n_out = 1'b0;
		sdi_out = 1'b0;
		// Short select at time zero gives the serial side a reset edge
		#1 cs_n_out = 1'b1;
	end
	// Released data line shows the inverse so stale bits never pass
	task automatic xfer(input logic [15:0] w, input int nbits,
		output logic [15:0] rd);
		rd = 16'h0000;
		#7 cs_n_out = 1'b0;
		#25 rd[15] = sdo_in;
		for (int k = 0; k < nbits; k++) begin
			sdi_out = w[15-k];
			// Edges sit off the core clock edges so the domains stay apart
			#12 sck_out = 1'b1;
			#15 sck_out = 1'b0;
			#3 if (k < 15) rd[14-k] = sdo_in;
		end
		#14 cs_n_out = 1'b1;
		sdi_out = ~sdi_out;
	endtask
endmodule

// ==== test/tcd_monitor.sv ====
/*
 Checker on the decoder's top-level ports.
 Bound from the bench top file; samples serial and core ports on the core clock.
*/
`timescale 1ns/1ps
module tcd_monitor (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic spi_sck_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_sdo_out,
	input wire logic spi_sdo_oe_out,
	input wire logic tx_ready_rx_fill_flag_in,
	input wire logic power_on_flag_in,
	input wire logic underrun_overflow_flag_in,
	input wire logic wake_timer_flag_in,
	input wire logic external_edge_flag_in,
	input wire logic event_pending_out,
	input wire logic tx_byte_load_out,
	input wire logic rx_byte_taken_out,
	input wire logic [7:0] general_config_out,
	input wire logic [7:0] tx_byte_value_out,
	input wire logic [12:0] wake_timer_period_out,
	input wire logic [7:0] pll_config_out
);
	// ****************************************
	// Port relations
	// ****************************************
	wire any_ev = tx_ready_rx_fill_flag_in | power_on_flag_in |
		underrun_overflow_flag_in | wake_timer_flag_in | external_edge_flag_in;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	sequence ev_s;
		any_ev;
	endsequence
	sequence defaults_s;
		general_config_out == 8'h08 && tx_byte_value_out == 8'haa &&
		wake_timer_period_out == 13'h0196 && pll_config_out == 8'h77;
	endsequence
	sdo_enable_a: assert property (spi_sdo_oe_out == !spi_cs_n_in)
		else $error("sdo enable differs from select");
	sdo_idle_a: assert property (spi_cs_n_in |-> !spi_sdo_out)
		else $error("sdo not low while deselected");
	sdo_edge_a: assert property (!spi_cs_n_in && $changed(spi_sdo_out)
		|-> !spi_sck_in) else $error("sdo moved while sck high");
	reset_values_a: assert property ($rose(nrst_in) |-> defaults_s)
		else $error("payload not at default after reset");
	tx_pulse_a: assert property (tx_byte_load_out |=> !tx_byte_load_out)
		else $error("load pulse longer than one cycle");
	rx_pulse_a: assert property (rx_byte_taken_out |=> !rx_byte_taken_out)
		else $error("taken pulse longer than one cycle");
	tx_value_a: assert property ($changed(tx_byte_value_out)
		|-> ##[0:1] tx_byte_load_out) else $error("tx byte moved without load");
	event_set_a: assert property (ev_s |=> event_pending_out)
		else $error("event did not raise pending");
	event_hold_a: assert property (!event_pending_out && !any_ev
		|=> !event_pending_out) else $error("pending rose without event");
endmodule
